// ---- hw/seq_defs.svh ----
// constants for the inherent bus cycle sequencer
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// opcode bytes
`define OP_PAGE_Y 8'h18
`define OP_STACK_FROM_INDEX 8'h35
`define OP_INDEX_FROM_STACK 8'h30
`define OP_WAIT_FOR_INTERRUPT 8'h38
`define OP_SWAP_D_INDEX 8'h8F
`define OP_PUSH_INDEX 8'h3C
`define OP_ADD_B_TO_INDEX 8'h3A
`define OP_INC_INDEX 8'h08
`define OP_DEC_INDEX 8'h09
`define OP_STACK_INCREMENT 8'h31
`define OP_STACK_DECREMENT 8'h34
`define OP_PUSH_ACC_A 8'h36
`define OP_PUSH_ACC_B 8'h37
`define OP_SHIFT_LEFT_D 8'h05
`define OP_SHIFT_RIGHT_D 8'h04
`define OP_COPY_A_TO_B 8'h16
`define OP_COPY_B_TO_A 8'h17
`define OP_COPY_A_TO_FLAGS 8'h06
`define OP_COPY_FLAGS_TO_A 8'h07
`define OP_ADD_B_TO_A 8'h1B

// addresses and reset values
`define ADDR_DUMMY 16'hFFFF
`define ADDR_WAIT_VECTOR 16'hFFF2
`define ADDR_ONE 16'h0001
`define ADDR_TWO 16'h0002
`define RESET_PC 16'h0000
`define RESET_SP 16'h00FF
`define RESET_BYTE 8'h00
`define DIRECT_PAGE 8'h00

// stacking during wait: nine bytes, index 0 to 8
`define WAIT_STACK_LAST 4'h8
`define WAIT_STACK_DEPTH 16'h0009
`define STACK_IDX_ZERO 4'h0
`define STACK_IDX_ONE 4'h1

`endif

// ---- hw/seq_pkg.sv ----
// types shared by the sequencer and its operand address former
package seq_pkg;

  typedef enum logic [3:0] {
    S_FETCH = 4'h0,
    S_FETCH2 = 4'h1,
    S_DUMMY = 4'h2,
    S_LAST = 4'h3,
    S_PUSH1 = 4'h4,
    S_PUSH2 = 4'h5,
    S_STACK = 4'h6,
    S_STACK_END = 4'h7,
    S_IDLE = 4'h8,
    S_VEC_HI = 4'h9,
    S_VEC_LO = 4'hA
  } bus_state_e;

  typedef enum logic [2:0] {
    CL_TWO = 3'h0,
    CL_DUMMY_FFFF = 3'h1,
    CL_DUMMY_SP = 3'h2,
    CL_PUSH_ACC = 3'h3,
    CL_PUSH_INDEX = 3'h4,
    CL_WAIT = 3'h5
  } op_class_e;

  typedef enum logic [2:0] {
    AM_DIRECT = 3'h0,
    AM_INDEXED_X = 3'h1,
    AM_INDEXED_Y = 3'h2,
    AM_RELATIVE = 3'h3,
    AM_EXTENDED = 3'h4,
    AM_IMMEDIATE16 = 3'h5
  } addr_mode_e;

endpackage : seq_pkg

// ---- hw/operand_address_former.sv ----
// operand byte conventions of the non-inherent addressing modes
`timescale 1ns/1ps
`include "seq_defs.svh"

module operand_address_former (
  // operand bytes, in bus order
  input wire seq_pkg::addr_mode_e mode,
  input wire logic [7:0] first_byte,
  input wire logic [7:0] second_byte,
  // address context
  input wire logic [15:0] follow_addr,
  input wire logic [15:0] index_x,
  input wire logic [15:0] index_y,
  // bit manipulation
  input wire logic [7:0] mem_data,
  // results
  output logic [15:0] ea,
  output logic [7:0] mask_set,
  output logic [7:0] mask_clear
);

  always_comb begin
    case (mode)
      seq_pkg::AM_DIRECT: ea = {`DIRECT_PAGE, first_byte};
      seq_pkg::AM_INDEXED_X: ea = index_x + {8'h00, first_byte};
      seq_pkg::AM_INDEXED_Y: ea = index_y + {8'h00, first_byte};
      // offset counts from the byte after the offset itself
      seq_pkg::AM_RELATIVE: ea = follow_addr + {{8{first_byte[7]}}, first_byte};
      seq_pkg::AM_EXTENDED: ea = {first_byte, second_byte};
      seq_pkg::AM_IMMEDIATE16: ea = {first_byte, second_byte};
      default: ea = {first_byte, second_byte};
    endcase
  end

  // mask is the second operand byte; set bits pick the bits touched
  assign mask_set = mem_data | second_byte;
  assign mask_clear = mem_data & ~second_byte;

endmodule : operand_address_former

// ---- hw/inherent_bus_cycle_sequencer.sv ----
// bus cycle sequencer for register transfer and inherent instructions
// Operation
// - stack_from_x: one byte, three cycles, stack pointer becomes x minus one
// - stack_from_y: prefix 18 then 35, four cycles, stack pointer becomes y minus one
// - wait_for_interrupt_op uses 12 cycles from opcode fetch before waiting
// - wait lasts n cycles until interrupt, then two vector fetches, 14+n total
// - direct operand gives low address byte, high byte forced to zero
// - indexed operand is unsigned 0..255 added to the chosen index
// - relative offset is signed, added to address after the offset byte
// - mask operand is eight bits; set bits choose affected memory bits
// - 16-bit immediate arrives high byte first, low byte second
// - extended address arrives high byte first, low byte second
// - two-cycle inherent: opcode read, then ignored read at opcode plus one
// - three-cycle x ops: opcode, dummy at opcode plus one, dummy at FFFF
// - four-cycle y ops: prefix, opcode, dummy opcode plus two, dummy FFFF
// - y_from_stack: prefix, 30, dummy opcode plus two, dummy at stack pointer
// - accumulator push: opcode, dummy, then write accumulator at stack pointer
// - push_index_x: opcode, dummy, write low at sp, high at sp minus one
// - push_index_y: five cycles, low byte at sp, high at sp minus one
`timescale 1ns/1ps
`include "seq_defs.svh"

module inherent_bus_cycle_sequencer (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // cpu bus
  input wire logic [7:0] bus_rdata,
  output logic [15:0] bus_addr,
  output logic bus_rw,
  output logic [7:0] bus_wdata,
  output logic opcode_fetch,
  // interrupt
  input wire logic irq_recognised,
  output logic wait_active,
  // programmer visible state
  output logic [15:0] stack_pointer,
  output logic [15:0] index_reg_x,
  output logic [15:0] index_reg_y,
  output logic [7:0] acc_a,
  output logic [7:0] acc_b,
  // operand address former
  input wire seq_pkg::addr_mode_e oper_mode,
  input wire logic [7:0] oper_first,
  input wire logic [7:0] oper_second,
  input wire logic [15:0] oper_follow_addr,
  input wire logic [7:0] oper_mem_data,
  output logic [15:0] oper_ea,
  output logic [7:0] oper_mask_set,
  output logic [7:0] oper_mask_clear
);

  seq_pkg::bus_state_e state_q;
  seq_pkg::bus_state_e state_d;
  seq_pkg::op_class_e class_q;
  seq_pkg::op_class_e class_now;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic rw_q;
  logic rw_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic fetch_q;
  logic wait_q;
  logic done_d;
  logic [15:0] pc_q;
  logic [15:0] sp_q;
  logic [15:0] ix_q;
  logic [15:0] iy_q;
  logic [7:0] a_q;
  logic [7:0] b_q;
  logic [7:0] ccr_q;
  logic [7:0] op_q;
  logic page_y_q;
  logic [3:0] stk_idx_q;
  logic [7:0] vec_hi_q;
  logic [15:0] index_sel;
  logic [15:0] ea_w;
  logic [7:0] mask_set_w;
  logic [7:0] mask_clear_w;
  logic [15:0] ea_q;
  logic [7:0] mask_set_q;
  logic [7:0] mask_clear_q;

  // instruction class from the byte that ends opcode fetch
  function automatic seq_pkg::op_class_e classify(input logic page_y, input logic [7:0] op);
    seq_pkg::op_class_e c;
    c = seq_pkg::CL_TWO;
    if (page_y) begin
      case (op)
        `OP_STACK_FROM_INDEX, `OP_ADD_B_TO_INDEX, `OP_INC_INDEX,
        `OP_DEC_INDEX, `OP_SWAP_D_INDEX: c = seq_pkg::CL_DUMMY_FFFF;
        `OP_INDEX_FROM_STACK: c = seq_pkg::CL_DUMMY_SP;
        `OP_PUSH_INDEX: c = seq_pkg::CL_PUSH_INDEX;
        default: c = seq_pkg::CL_DUMMY_FFFF;
      endcase
    end else begin
      case (op)
        `OP_STACK_FROM_INDEX, `OP_ADD_B_TO_INDEX, `OP_INC_INDEX, `OP_DEC_INDEX,
        `OP_SWAP_D_INDEX, `OP_SHIFT_LEFT_D, `OP_SHIFT_RIGHT_D: c = seq_pkg::CL_DUMMY_FFFF;
        `OP_STACK_INCREMENT, `OP_STACK_DECREMENT,
        `OP_INDEX_FROM_STACK: c = seq_pkg::CL_DUMMY_SP;
        `OP_PUSH_ACC_A, `OP_PUSH_ACC_B: c = seq_pkg::CL_PUSH_ACC;
        `OP_PUSH_INDEX: c = seq_pkg::CL_PUSH_INDEX;
        `OP_WAIT_FOR_INTERRUPT: c = seq_pkg::CL_WAIT;
        default: c = seq_pkg::CL_TWO;
      endcase
    end
    return c;
  endfunction : classify

  // byte k of the wait stacking frame, written at sp minus k
  function automatic logic [7:0] stack_byte(input logic [3:0] k, input logic [15:0] pc,
                                            input logic [15:0] x, input logic [15:0] y,
                                            input logic [7:0] a, input logic [7:0] b,
                                            input logic [7:0] ccr);
    logic [7:0] v;
    v = `RESET_BYTE;
    case (k)
      4'h0: v = pc[7:0];
      4'h1: v = pc[15:8];
      4'h2: v = y[7:0];
      4'h3: v = y[15:8];
      4'h4: v = x[7:0];
      4'h5: v = x[15:8];
      4'h6: v = a;
      4'h7: v = b;
      4'h8: v = ccr;
      default: v = `RESET_BYTE;
    endcase
    return v;
  endfunction : stack_byte

  assign index_sel = page_y_q ? iy_q : ix_q;
  assign class_now = classify(state_q == seq_pkg::S_FETCH2, bus_rdata);

  // next bus cycle; read/write is high unless a stack write is chosen
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    rw_d = 1'b1;
    wdata_d = `RESET_BYTE;
    done_d = 1'b0;
    case (state_q)
      seq_pkg::S_FETCH: begin
        addr_d = pc_q + `ADDR_ONE;
        if (bus_rdata == `OP_PAGE_Y) begin
          state_d = seq_pkg::S_FETCH2;
        end else begin
          state_d = seq_pkg::S_DUMMY;
        end
      end
      seq_pkg::S_FETCH2: begin
        // pc already points past the prefix, so this is opcode plus two
        addr_d = pc_q + `ADDR_ONE;
        state_d = seq_pkg::S_DUMMY;
      end
      seq_pkg::S_DUMMY: begin
        case (class_q)
          seq_pkg::CL_TWO: begin
            done_d = 1'b1;
            addr_d = pc_q;
            state_d = seq_pkg::S_FETCH;
          end
          seq_pkg::CL_DUMMY_FFFF: begin
            addr_d = `ADDR_DUMMY;
            state_d = seq_pkg::S_LAST;
          end
          seq_pkg::CL_DUMMY_SP: begin
            addr_d = sp_q;
            state_d = seq_pkg::S_LAST;
          end
          seq_pkg::CL_PUSH_ACC: begin
            addr_d = sp_q;
            rw_d = 1'b0;
            wdata_d = (op_q == `OP_PUSH_ACC_A) ? a_q : b_q;
            state_d = seq_pkg::S_PUSH1;
          end
          seq_pkg::CL_PUSH_INDEX: begin
            addr_d = sp_q;
            rw_d = 1'b0;
            wdata_d = index_sel[7:0];
            state_d = seq_pkg::S_PUSH1;
          end
          seq_pkg::CL_WAIT: begin
            addr_d = sp_q;
            rw_d = 1'b0;
            wdata_d = stack_byte(`STACK_IDX_ZERO, pc_q, ix_q, iy_q, a_q, b_q, ccr_q);
            state_d = seq_pkg::S_STACK;
          end
          default: begin
            done_d = 1'b1;
            addr_d = pc_q;
            state_d = seq_pkg::S_FETCH;
          end
        endcase
      end
      seq_pkg::S_LAST, seq_pkg::S_PUSH2: begin
        done_d = 1'b1;
        addr_d = pc_q;
        state_d = seq_pkg::S_FETCH;
      end
      seq_pkg::S_PUSH1: begin
        if (class_q == seq_pkg::CL_PUSH_INDEX) begin
          addr_d = sp_q - `ADDR_ONE;
          rw_d = 1'b0;
          wdata_d = index_sel[15:8];
          state_d = seq_pkg::S_PUSH2;
        end else begin
          done_d = 1'b1;
          addr_d = pc_q;
          state_d = seq_pkg::S_FETCH;
        end
      end
      seq_pkg::S_STACK: begin
        if (stk_idx_q == `WAIT_STACK_LAST) begin
          addr_d = `ADDR_DUMMY;
          state_d = seq_pkg::S_STACK_END;
        end else begin
          addr_d = sp_q - {12'h000, stk_idx_q + `STACK_IDX_ONE};
          rw_d = 1'b0;
          wdata_d = stack_byte(stk_idx_q + `STACK_IDX_ONE, pc_q, ix_q, iy_q, a_q, b_q, ccr_q);
        end
      end
      seq_pkg::S_STACK_END: begin
        addr_d = `ADDR_DUMMY;
        state_d = seq_pkg::S_IDLE;
      end
      seq_pkg::S_IDLE: begin
        // dummy reads at FFFF keep the bus quiet while waiting
        if (irq_recognised) begin
          addr_d = `ADDR_WAIT_VECTOR;
          state_d = seq_pkg::S_VEC_HI;
        end else begin
          addr_d = `ADDR_DUMMY;
        end
      end
      seq_pkg::S_VEC_HI: begin
        addr_d = `ADDR_WAIT_VECTOR + `ADDR_ONE;
        state_d = seq_pkg::S_VEC_LO;
      end
      seq_pkg::S_VEC_LO: begin
        addr_d = {vec_hi_q, bus_rdata};
        state_d = seq_pkg::S_FETCH;
      end
      default: begin
        addr_d = pc_q;
        state_d = seq_pkg::S_FETCH;
      end
    endcase
  end

  // bus outputs and sequence state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= seq_pkg::S_FETCH;
      addr_q <= `RESET_PC;
      rw_q <= 1'b1;
      wdata_q <= `RESET_BYTE;
      fetch_q <= 1'b1;
      wait_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      wdata_q <= wdata_d;
      fetch_q <= (state_d == seq_pkg::S_FETCH);
      wait_q <= (state_d == seq_pkg::S_IDLE);
    end
  end

  // opcode capture and classification
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= `RESET_BYTE;
      page_y_q <= 1'b0;
      class_q <= seq_pkg::CL_TWO;
    end else if (state_q == seq_pkg::S_FETCH) begin
      op_q <= bus_rdata;
      page_y_q <= 1'b0;
      class_q <= class_now;
    end else if (state_q == seq_pkg::S_FETCH2) begin
      op_q <= bus_rdata;
      page_y_q <= 1'b1;
      class_q <= class_now;
    end
  end

  // program counter advances on opcode bytes only; vector loads it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= `RESET_PC;
      vec_hi_q <= `RESET_BYTE;
    end else begin
      case (state_q)
        seq_pkg::S_FETCH, seq_pkg::S_FETCH2: pc_q <= pc_q + `ADDR_ONE;
        seq_pkg::S_VEC_HI: vec_hi_q <= bus_rdata;
        seq_pkg::S_VEC_LO: pc_q <= {vec_hi_q, bus_rdata};
        default: pc_q <= pc_q;
      endcase
    end
  end

  // wait stacking byte counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stk_idx_q <= `STACK_IDX_ZERO;
    end else if (state_q == seq_pkg::S_STACK) begin
      stk_idx_q <= stk_idx_q + `STACK_IDX_ONE;
    end else begin
      stk_idx_q <= `STACK_IDX_ZERO;
    end
  end

  // stack pointer; it holds its old value until the last cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= `RESET_SP;
    end else if (state_q == seq_pkg::S_STACK_END) begin
      sp_q <= sp_q - `WAIT_STACK_DEPTH;
    end else if (done_d) begin
      case (class_q)
        seq_pkg::CL_PUSH_ACC: sp_q <= sp_q - `ADDR_ONE;
        seq_pkg::CL_PUSH_INDEX: sp_q <= sp_q - `ADDR_TWO;
        default: begin
          if (op_q == `OP_STACK_FROM_INDEX) begin
            sp_q <= index_sel - `ADDR_ONE;
          end else if (!page_y_q && op_q == `OP_STACK_INCREMENT) begin
            sp_q <= sp_q + `ADDR_ONE;
          end else if (!page_y_q && op_q == `OP_STACK_DECREMENT) begin
            sp_q <= sp_q - `ADDR_ONE;
          end
        end
      endcase
    end
  end

  // index registers and accumulators change when the instruction ends
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ix_q <= `RESET_PC;
      iy_q <= `RESET_PC;
      a_q <= `RESET_BYTE;
      b_q <= `RESET_BYTE;
      ccr_q <= `RESET_BYTE;
    end else if (done_d) begin
      case (op_q)
        `OP_INDEX_FROM_STACK: begin
          if (page_y_q) iy_q <= sp_q + `ADDR_ONE;
          else ix_q <= sp_q + `ADDR_ONE;
        end
        `OP_ADD_B_TO_INDEX: begin
          if (page_y_q) iy_q <= iy_q + {8'h00, b_q};
          else ix_q <= ix_q + {8'h00, b_q};
        end
        `OP_INC_INDEX: begin
          if (page_y_q) iy_q <= iy_q + `ADDR_ONE;
          else ix_q <= ix_q + `ADDR_ONE;
        end
        `OP_DEC_INDEX: begin
          if (page_y_q) iy_q <= iy_q - `ADDR_ONE;
          else ix_q <= ix_q - `ADDR_ONE;
        end
        `OP_SWAP_D_INDEX: begin
          {a_q, b_q} <= index_sel;
          if (page_y_q) iy_q <= {a_q, b_q};
          else ix_q <= {a_q, b_q};
        end
        `OP_SHIFT_LEFT_D: if (!page_y_q) {a_q, b_q} <= {a_q[6:0], b_q, 1'b0};
        `OP_SHIFT_RIGHT_D: if (!page_y_q) {a_q, b_q} <= {1'b0, a_q, b_q[7:1]};
        `OP_COPY_A_TO_B: if (!page_y_q) b_q <= a_q;
        `OP_COPY_B_TO_A: if (!page_y_q) a_q <= b_q;
        `OP_COPY_A_TO_FLAGS: if (!page_y_q) ccr_q <= a_q;
        `OP_COPY_FLAGS_TO_A: if (!page_y_q) a_q <= ccr_q;
        `OP_ADD_B_TO_A: if (!page_y_q) a_q <= a_q + b_q;
        default: a_q <= a_q;
      endcase
    end
  end

  // operand conventions of the other modes, registered for the outputs
  operand_address_former u_former (
    .mode(oper_mode),
    .first_byte(oper_first),
    .second_byte(oper_second),
    .follow_addr(oper_follow_addr),
    .index_x(ix_q),
    .index_y(iy_q),
    .mem_data(oper_mem_data),
    .ea(ea_w),
    .mask_set(mask_set_w),
    .mask_clear(mask_clear_w)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ea_q <= `RESET_PC;
      mask_set_q <= `RESET_BYTE;
      mask_clear_q <= `RESET_BYTE;
    end else begin
      ea_q <= ea_w;
      mask_set_q <= mask_set_w;
      mask_clear_q <= mask_clear_w;
    end
  end

  assign bus_addr = addr_q;
  assign bus_rw = rw_q;
  assign bus_wdata = wdata_q;
  assign opcode_fetch = fetch_q;
  assign wait_active = wait_q;
  assign stack_pointer = sp_q;
  assign index_reg_x = ix_q;
  assign index_reg_y = iy_q;
  assign acc_a = a_q;
  assign acc_b = b_q;
  assign oper_ea = ea_q;
  assign oper_mask_set = mask_set_q;
  assign oper_mask_clear = mask_clear_q;

endmodule : inherent_bus_cycle_sequencer

// ---- testbench/bus_memory_model.sv ----
// memory answering the cpu bus of the sequencer
`timescale 1ns/1ps

module bus_memory_model (
  // clock
  input wire logic clock,
  // cpu bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_rw,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata
);
  // unloaded space reads 01, a two-cycle opcode, so no unknown is ever decoded
  logic [7:0] mem [0:65535] = '{default: 8'h01};

  // zero wait states: read data follows the address within the cycle
  assign bus_rdata = mem[bus_addr];

  always @(posedge clock) begin
    if (!bus_rw) begin
      mem[bus_addr] <= bus_wdata;
    end
  end

  task load(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask : load
endmodule : bus_memory_model

// ---- testbench/inherent_bus_cycle_sequencer_sva.sv ----
// concurrent checks on the sequencer ports
`timescale 1ns/1ps

module inherent_bus_cycle_sequencer_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // cpu bus
  input wire logic [7:0] bus_rdata,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rw,
  input wire logic [7:0] bus_wdata,
  input wire logic opcode_fetch,
  // interrupt and state
  input wire logic irq_recognised,
  input wire logic wait_active,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] index_reg_x,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  // operand former
  input wire seq_pkg::addr_mode_e oper_mode,
  input wire logic [7:0] oper_first,
  input wire logic [15:0] oper_ea
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_fetch_is_read;
    opcode_fetch |-> bus_rw && bus_wdata == 8'h00;
  endproperty
  a_fetch_is_read: assert property (p_fetch_is_read) else $error("fetch not a read");

  property p_two_cycle;
    opcode_fetch && bus_rdata == 8'h16 |=> bus_addr == $past(bus_addr) + 16'h0001 && bus_rw
      ##1 opcode_fetch && bus_addr == $past(bus_addr, 2) + 16'h0001;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("two cycle form wrong");

  property p_x_three;
    opcode_fetch && bus_rdata inside {8'h35, 8'h08, 8'h09, 8'h3A, 8'h8F}
      |=> bus_addr == $past(bus_addr) + 16'h0001 ##1 bus_addr == 16'hFFFF && bus_rw
      ##1 opcode_fetch;
  endproperty
  a_x_three: assert property (p_x_three) else $error("x op cycles wrong");

  property p_stack_adj;
    opcode_fetch && bus_rdata inside {8'h31, 8'h34, 8'h30}
      |=> ##1 bus_addr == $past(stack_pointer, 2) && bus_rw ##1 opcode_fetch;
  endproperty
  a_stack_adj: assert property (p_stack_adj) else $error("old stack dummy wrong");

  property p_push_acc;
    opcode_fetch && bus_rdata inside {8'h36, 8'h37} |=> ##1 !bus_rw
      && bus_addr == $past(stack_pointer, 2)
      && bus_wdata == ($past(bus_rdata, 2) == 8'h36 ? acc_a : acc_b) ##1 opcode_fetch;
  endproperty
  a_push_acc: assert property (p_push_acc) else $error("acc push wrong");

  property p_push_x;
    opcode_fetch && bus_rdata == 8'h3C |=> ##1 !bus_rw && bus_addr == $past(stack_pointer, 2)
      && bus_wdata == index_reg_x[7:0] ##1 !bus_rw && bus_wdata == index_reg_x[15:8]
      && bus_addr == $past(stack_pointer, 3) - 16'h0001 ##1 opcode_fetch;
  endproperty
  a_push_x: assert property (p_push_x) else $error("index push wrong");

  sequence s_page_y;
    opcode_fetch && bus_rdata == 8'h18 ##1 bus_rdata inside {8'h35, 8'h3A, 8'h08, 8'h09, 8'h8F};
  endsequence
  property p_y_four;
    s_page_y |=> bus_addr == $past(bus_addr) + 16'h0001 && bus_rw
      ##1 bus_addr == 16'hFFFF && bus_rw ##1 opcode_fetch;
  endproperty
  a_y_four: assert property (p_y_four) else $error("y op cycles wrong");

  property p_wait_stack;
    opcode_fetch && bus_rdata == 8'h38 |=> ##1 (!bus_rw) [*8] ##1 !bus_rw
      ##1 bus_rw && bus_addr == 16'hFFFF && !wait_active ##1 wait_active;
  endproperty
  a_wait_stack: assert property (p_wait_stack) else $error("wait entry wrong");

  property p_wait_exit;
    wait_active && irq_recognised |=> !wait_active && bus_addr == 16'hFFF2 && bus_rw
      ##1 bus_addr == 16'hFFF3 && bus_rw ##1 opcode_fetch;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("vector fetch wrong");

  // registered result pairs with last cycle's inputs
  property p_direct;
    $past(oper_mode) == seq_pkg::AM_DIRECT |-> oper_ea == {8'h00, $past(oper_first)};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");

  c_wait_exit: cover property (wait_active && irq_recognised);
  c_push_x: cover property (opcode_fetch && bus_rdata == 8'h3C);
  c_push_y: cover property (opcode_fetch && bus_rdata == 8'h18 ##1 bus_rdata == 8'h3C);
endmodule : inherent_bus_cycle_sequencer_sva

bind inherent_bus_cycle_sequencer inherent_bus_cycle_sequencer_sva
  inherent_bus_cycle_sequencer_sva_inst (.clock, .rst_n, .bus_rdata, .bus_addr, .bus_rw,
  .bus_wdata, .opcode_fetch, .irq_recognised, .wait_active, .stack_pointer, .index_reg_x,
  .acc_a, .acc_b, .oper_mode, .oper_first, .oper_ea);

// ---- testbench/test_inherent_bus_cycle_sequencer.sv ----
// self-checking bench walking the sequencer through its bus cycle tables
`timescale 1ns/1ps

module test_inherent_bus_cycle_sequencer;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic irq_recognised = 1'b0;
  seq_pkg::addr_mode_e oper_mode = seq_pkg::AM_DIRECT;
  logic [7:0] oper_first = 8'h00;
  logic [7:0] oper_second = 8'h00;
  logic [15:0] oper_follow_addr = 16'h0000;
  logic [7:0] oper_mem_data = 8'h0F;
  logic [7:0] bus_rdata;
  logic [15:0] bus_addr;
  logic bus_rw;
  logic [7:0] bus_wdata;
  logic opcode_fetch;
  logic wait_active;
  logic [15:0] stack_pointer;
  logic [15:0] index_reg_x;
  logic [15:0] index_reg_y;
  logic [7:0] acc_a;
  logic [7:0] acc_b;
  logic [15:0] oper_ea;
  logic [7:0] oper_mask_set;
  logic [7:0] oper_mask_clear;
  logic irq_v = 1'b0;
  logic wact_v = 1'b0;
  logic skip_wd = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  logic [7:0] prog [20] = '{8'h16, 8'h30, 8'h08, 8'h08, 8'h35, 8'h3C, 8'h8F, 8'h36, 8'h37,
    8'h31, 8'h34, 8'h18, 8'h30, 8'h18, 8'h08, 8'h18, 8'h35, 8'h18, 8'h3C, 8'h38};
  logic [7:0] stacked [8] = '{8'h14, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};

  always #50 clock = ~clock;

  inherent_bus_cycle_sequencer inherent_bus_cycle_sequencer_inst (.clock, .rst_n, .bus_rdata,
    .bus_addr, .bus_rw, .bus_wdata, .opcode_fetch, .irq_recognised, .wait_active,
    .stack_pointer, .index_reg_x, .index_reg_y, .acc_a, .acc_b, .oper_mode, .oper_first,
    .oper_second, .oper_follow_addr, .oper_mem_data, .oper_ea, .oper_mask_set, .oper_mask_clear);

  bus_memory_model bus_memory_model_inst (.clock, .bus_addr, .bus_rw, .bus_wdata, .bus_rdata);

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one bus cycle, checked once its outputs settle
  task cyc(input logic [15:0] a, input logic f = 1'b0, input logic [7:0] w = 8'h00,
    input logic rw = 1'b1);
    @(posedge clock);
    rst_n <= 1'b1;
    irq_recognised <= irq_v;
    #1;
    check("bus_addr", bus_addr, a);
    check("bus_rw", 16'(bus_rw), 16'(rw));
    check("opcode_fetch", 16'(opcode_fetch), 16'(f));
    check("wait_active", 16'(wait_active), 16'(wact_v));
    if (!skip_wd) begin
      check("bus_wdata", 16'(bus_wdata), 16'(w));
    end
  endtask : cyc

  task t_two_cycle;
    cyc(16'h0000, 1'b1);
    cyc(16'h0001);
    $display("test two_cycle done");
  endtask : t_two_cycle

  task t_x_ops;
    cyc(16'h0001, 1'b1);
    cyc(16'h0002);
    cyc(16'h00FF);
    cyc(16'h0002, 1'b1);
    cyc(16'h0003);
    cyc(16'hFFFF);
    cyc(16'h0003, 1'b1);
    cyc(16'h0004);
    cyc(16'hFFFF);
    cyc(16'h0004, 1'b1);
    cyc(16'h0005);
    cyc(16'hFFFF);
    $display("test x_ops done");
  endtask : t_x_ops

  task t_push;
    cyc(16'h0005, 1'b1);
    cyc(16'h0006);
    cyc(16'h0101, 1'b0, 8'h02, 1'b0);
    cyc(16'h0100, 1'b0, 8'h01, 1'b0);
    cyc(16'h0006, 1'b1);
    cyc(16'h0007);
    cyc(16'hFFFF);
    cyc(16'h0007, 1'b1);
    cyc(16'h0008);
    cyc(16'h00FF, 1'b0, 8'h01, 1'b0);
    cyc(16'h0008, 1'b1);
    cyc(16'h0009);
    cyc(16'h00FE, 1'b0, 8'h02, 1'b0);
    check("index_reg_x", index_reg_x, 16'h0000);
    $display("test push done");
  endtask : t_push

  task t_stack_adj;
    cyc(16'h0009, 1'b1);
    cyc(16'h000A);
    cyc(16'h00FD);
    cyc(16'h000A, 1'b1);
    cyc(16'h000B);
    cyc(16'h00FE);
    $display("test stack_adj done");
  endtask : t_stack_adj

  task t_y_ops;
    cyc(16'h000B, 1'b1);
    cyc(16'h000C);
    cyc(16'h000D);
    cyc(16'h00FD);
    cyc(16'h000D, 1'b1);
    cyc(16'h000E);
    cyc(16'h000F);
    cyc(16'hFFFF);
    cyc(16'h000F, 1'b1);
    cyc(16'h0010);
    cyc(16'h0011);
    cyc(16'hFFFF);
    cyc(16'h0011, 1'b1);
    cyc(16'h0012);
    cyc(16'h0013);
    cyc(16'h00FE, 1'b0, 8'hFF, 1'b0);
    cyc(16'h00FD, 1'b0, 8'h00, 1'b0);
    check("index_reg_y", index_reg_y, 16'h00FF);
    $display("test y_ops done");
  endtask : t_y_ops

  // n = 3 idle cycles, so the whole instruction spans 17 cycles
  task t_wait;
    cyc(16'h0013, 1'b1);
    cyc(16'h0014);
    for (int i = 0; i < 8; i++) begin
      cyc(16'h00FC - 16'(i), 1'b0, stacked[i], 1'b0);
    end
    // condition code byte left unchecked
    skip_wd = 1'b1;
    cyc(16'h00F4, 1'b0, 8'h00, 1'b0);
    skip_wd = 1'b0;
    cyc(16'hFFFF);
    wact_v = 1'b1;
    cyc(16'hFFFF);
    cyc(16'hFFFF);
    irq_v = 1'b1;
    cyc(16'hFFFF);
    irq_v = 1'b0;
    wact_v = 1'b0;
    cyc(16'hFFF2);
    cyc(16'hFFF3);
    cyc(16'h0020, 1'b1);
    check("stack_pointer", stack_pointer, 16'h00F3);
    $display("test wait done");
  endtask : t_wait

  task opc(input seq_pkg::addr_mode_e m, input logic [7:0] f, input logic [15:0] fo,
    input logic [15:0] e);
    @(posedge clock);
    oper_mode <= m;
    oper_first <= f;
    oper_second <= 8'h3C;
    oper_follow_addr <= fo;
    @(posedge clock);
    #1;
    check("oper_ea", oper_ea, e);
  endtask : opc

  // x is 0000 and y is 00FF by now
  task t_operand;
    opc(seq_pkg::AM_DIRECT, 8'hAB, 16'h0000, 16'h00AB);
    opc(seq_pkg::AM_INDEXED_X, 8'hFF, 16'h0000, 16'h00FF);
    opc(seq_pkg::AM_INDEXED_Y, 8'h80, 16'h0000, 16'h017F);
    opc(seq_pkg::AM_RELATIVE, 8'h80, 16'h1000, 16'h0F80);
    opc(seq_pkg::AM_RELATIVE, 8'h7F, 16'h1000, 16'h107F);
    opc(seq_pkg::AM_EXTENDED, 8'h12, 16'h0000, 16'h123C);
    opc(seq_pkg::AM_IMMEDIATE16, 8'h12, 16'h0000, 16'h123C);
    check("oper_mask_set", 16'(oper_mask_set), 16'h003F);
    check("oper_mask_clear", 16'(oper_mask_clear), 16'h0003);
    $display("test operand done");
  endtask : t_operand

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #1;
    for (int i = 0; i < 20; i++) begin
      bus_memory_model_inst.load(16'(i), prog[i]);
    end
    bus_memory_model_inst.load(16'hFFF2, 8'h00);
    bus_memory_model_inst.load(16'hFFF3, 8'h20);
    bus_memory_model_inst.load(16'h0020, 8'h16);
    repeat (5) @(posedge clock);
    t_two_cycle();
    t_x_ops();
    t_push();
    t_stack_adj();
    t_y_ops();
    t_wait();
    t_operand();
    final_report();
  end

  // tests take about 87 cycles; a hang stops far beyond
  initial begin
    repeat (2000) @(posedge clock);
    n_fail++;
    final_report();
  end
endmodule : test_inherent_bus_cycle_sequencer
